// *** include/conv_ctrl_regs.vh ***
// Register offsets, field positions and timing constants of the converter control block
`ifndef CONV_CTRL_REGS_VH
`define CONV_CTRL_REGS_VH
// Printed offsets are register indices; byte address is four times the index
`define IDX_DIDR 4'h1
`define IDX_CTRLB 4'h3
`define IDX_RESL 4'h4
`define IDX_RESH 4'h5
`define IDX_CTRLA 4'h6
`define ADDR_DIDR 12'h004
`define ADDR_CTRLB 12'h00c
`define ADDR_RESL 12'h010
`define ADDR_RESH 12'h014
`define ADDR_CTRLA 12'h018
// Own register: pin input view
`define ADDR_PINS 12'h020
// converter_control_a fields
`define A_ON 7
`define A_START 6
`define A_AUTO 5
`define A_DONE 4
`define A_IE 3
// converter_control_b fields
`define B_BIP 7
`define B_LEFT 4
`define REG_RESET 8'h00
`define FIRST_CYCLES 8'd25
`define NORMAL_CYCLES 8'd13
`define TRIG_FREE 3'h0
// Prescaler terminal counts, one less than the division factor
`define DIV_MAX_2 7'h01
`define DIV_MAX_4 7'h03
`define DIV_MAX_8 7'h07
`define DIV_MAX_16 7'h0f
`define DIV_MAX_32 7'h1f
`define DIV_MAX_64 7'h3f
`define DIV_MAX_128 7'h7f
`endif

// *** rtl/conv_ctrl.v ***
// Converter control, status and result logic with an APB register slave
//
// Chosen here: the APB register port.
`timescale 1ns/1ps
`include "conv_ctrl_regs.vh"
module conv_ctrl #(
  parameter DW = 10
) (
  input wire pclk,
  input wire presetn,
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [11:0] paddr,
  input wire [31:0] pwdata,
  output reg [31:0] prdata,
  output reg pready,
  output reg pslverr,
  input wire [DW-1:0] sample_pos,
  input wire [DW-1:0] sample_neg,
  input wire [6:0] trig_src,
  input wire global_irq_enable,
  input wire irq_ack,
  input wire [7:0] pin_in,
  output reg irq_req,
  output reg conv_power,
  output reg [7:0] input_buf_off,
  output reg [7:0] pin_view
);
  localparam S_IDLE = 2'b00;
  localparam S_CONV = 2'b01;

  reg [7:0] ctrl_a_q;
  reg [7:0] ctrl_b_q;
  reg [7:0] didr_q;
  reg [DW-1:0] result_q;
  reg [DW-1:0] res_latch_q;
  reg lock_q;
  reg [1:0] state_q;
  reg [7:0] cyc_q;
  reg [7:0] cyc_len_q;
  reg first_q;
  reg [6:0] pre_q;
  reg trig_prev_q;
  reg [DW-1:0] pos_s1_q, pos_s2_q, neg_s1_q, neg_s2_q;
  reg [6:0] trg_s1_q, trg_s2_q;
  reg [7:0] pin_s1_q, pin_s2_q;
  reg gie_s1_q, gie_s2_q;

  wire wr = psel & penable & pwrite;
  wire rd = psel & penable & ~pwrite;
  wire wr_a = wr & (paddr == `ADDR_CTRLA);
  wire wr_b = wr & (paddr == `ADDR_CTRLB);
  wire busy = (state_q == S_CONV);
  wire on_next = wr_a ? pwdata[`A_ON] : ctrl_a_q[`A_ON];

  // Prescaler terminal count per divider code
  reg [6:0] div_max;
  always @* begin
    case (ctrl_a_q[2:0])
      3'h0, 3'h1: div_max = `DIV_MAX_2;
      3'h2: div_max = `DIV_MAX_4;
      3'h3: div_max = `DIV_MAX_8;
      3'h4: div_max = `DIV_MAX_16;
      3'h5: div_max = `DIV_MAX_32;
      3'h6: div_max = `DIV_MAX_64;
      default: div_max = `DIV_MAX_128;
    endcase
  end
  wire adc_tick = (pre_q >= div_max);

  // Selected trigger signal; code 0 is free running and gives no edge
  reg trig_sel;
  always @* begin
    if (ctrl_b_q[2:0] == `TRIG_FREE)
      trig_sel = 1'b0;
    else
      trig_sel = trg_s2_q[ctrl_b_q[2:0] - 3'h1];
  end
  wire trig_edge = ctrl_a_q[`A_AUTO] & trig_sel & ~trig_prev_q;

  // Converted value from synchronised inputs
  reg [DW-1:0] conv_val;
  always @* begin
    if (ctrl_b_q[`B_BIP])
      conv_val = pos_s2_q - neg_s2_q;
    else if (neg_s2_q > pos_s2_q)
      conv_val = {DW{1'b0}};
    else
      conv_val = pos_s2_q - neg_s2_q;
  end

  wire free_mode = ctrl_a_q[`A_AUTO] & (ctrl_b_q[2:0] == `TRIG_FREE);
  wire sw_start = wr_a & pwdata[`A_START] & pwdata[`A_ON];
  wire conv_end = busy & adc_tick & (cyc_q == cyc_len_q - 8'd1);
  wire auto_start = (trig_edge | (free_mode & conv_end)) & ctrl_a_q[`A_ON];
  wire start = (sw_start | auto_start) & on_next & (~busy | conv_end);
  wire done_set = conv_end & on_next;
  wire upd_res = done_set & ~lock_q;

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pos_s1_q <= {DW{1'b0}};
      pos_s2_q <= {DW{1'b0}};
      neg_s1_q <= {DW{1'b0}};
      neg_s2_q <= {DW{1'b0}};
      trg_s1_q <= 7'h00;
      trg_s2_q <= 7'h00;
      pin_s1_q <= 8'h00;
      pin_s2_q <= 8'h00;
      gie_s1_q <= 1'b0;
      gie_s2_q <= 1'b0;
    end else begin
      pos_s1_q <= sample_pos;
      pos_s2_q <= pos_s1_q;
      neg_s1_q <= sample_neg;
      neg_s2_q <= neg_s1_q;
      trg_s1_q <= trig_src;
      trg_s2_q <= trg_s1_q;
      pin_s1_q <= pin_in;
      pin_s2_q <= pin_s1_q;
      gie_s1_q <= global_irq_enable;
      gie_s2_q <= gie_s1_q;
    end
  end

  // Prescaler runs only while a conversion is busy
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pre_q <= 7'h00;
    end else begin
      pre_q <= (adc_tick | ~busy) ? 7'h00 : pre_q + 7'h01;
    end
  end

  // Last level of the selected trigger, for edge detection
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      trig_prev_q <= 1'b0;
    end else begin
      trig_prev_q <= trig_sel;
    end
  end

  // Next state of the conversion sequencer
  reg [1:0] state_d;
  reg [7:0] cyc_d;
  reg [7:0] cyc_len_d;
  reg first_d;
  always @* begin
    state_d = state_q;
    cyc_d = cyc_q;
    cyc_len_d = cyc_len_q;
    first_d = first_q;
    case (state_q)
      S_IDLE: begin
        if (start) begin
          state_d = S_CONV;
          cyc_d = 8'h00;
          cyc_len_d = first_q ? `FIRST_CYCLES : `NORMAL_CYCLES;
          first_d = 1'b0;
        end
      end
      S_CONV: begin
        if (start) begin
          // Back-to-back conversion straight from completion
          cyc_d = 8'h00;
          cyc_len_d = first_q ? `FIRST_CYCLES : `NORMAL_CYCLES;
          first_d = 1'b0;
        end else if (conv_end) begin
          state_d = S_IDLE;
        end else if (adc_tick) begin
          cyc_d = cyc_q + 8'h01;
        end
      end
      default: begin
        state_d = S_IDLE;
      end
    endcase
    if (!on_next) begin
      state_d = S_IDLE;
      cyc_d = 8'h00;
      first_d = 1'b1;
    end
  end

  // Sequencer registers
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_q <= S_IDLE;
      cyc_q <= 8'h00;
      cyc_len_q <= `NORMAL_CYCLES;
      first_q <= 1'b1;
    end else begin
      state_q <= state_d;
      cyc_q <= cyc_d;
      cyc_len_q <= cyc_len_d;
      first_q <= first_d;
    end
  end

  // Control register A; hardware set of the done flag wins over a clear
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_a_q <= `REG_RESET;
    end else begin
      if (wr_a) begin
        ctrl_a_q[`A_ON] <= pwdata[`A_ON];
        ctrl_a_q[`A_AUTO] <= pwdata[`A_AUTO];
        ctrl_a_q[`A_IE] <= pwdata[`A_IE];
        ctrl_a_q[2:0] <= pwdata[2:0];
      end
      if (done_set)
        ctrl_a_q[`A_DONE] <= 1'b1;
      else if ((wr_a && pwdata[`A_DONE]) || irq_ack)
        ctrl_a_q[`A_DONE] <= 1'b0;
      // Busy bit follows the sequencer, so a written zero changes nothing
      ctrl_a_q[`A_START] <= start | (busy & ~conv_end & on_next);
    end
  end

  // Control register B, reserved bits kept as plain storage
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_b_q <= `REG_RESET;
    end else begin
      if (wr_b)
        ctrl_b_q <= pwdata[7:0];
    end
  end

  // Digital input disable
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      didr_q <= `REG_RESET;
    end else begin
      if (wr && paddr == `ADDR_DIDR)
        didr_q <= pwdata[7:0];
    end
  end

  // Result of the last completed, unlocked conversion
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      result_q <= {DW{1'b0}};
    end else begin
      if (upd_res)
        result_q <= conv_val;
    end
  end

  // Low-byte read freezes the pair until the high byte is read
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      res_latch_q <= {DW{1'b0}};
      lock_q <= 1'b0;
    end else begin
      if (rd && paddr == `ADDR_RESL) begin
        lock_q <= 1'b1;
        res_latch_q <= upd_res ? conv_val : result_q;
      end else if (rd && paddr == `ADDR_RESH)
        lock_q <= 1'b0;
    end
  end

  // Read view of result; justification applies at read time
  wire [DW-1:0] res_view = lock_q ? res_latch_q : result_q;
  wire [15:0] res_right = {{(16-DW){1'b0}}, res_view};
  wire [15:0] res_left = {res_view, {(16-DW){1'b0}}};
  wire [15:0] res_pair = ctrl_b_q[`B_LEFT] ? res_left : res_right;

  reg [7:0] rd_mux;
  reg addr_ok;
  always @* begin
    addr_ok = 1'b1;
    case (paddr)
      `ADDR_CTRLA: rd_mux = ctrl_a_q;
      `ADDR_CTRLB: rd_mux = ctrl_b_q;
      `ADDR_DIDR: rd_mux = didr_q;
      `ADDR_RESL: rd_mux = res_pair[7:0];
      `ADDR_RESH: rd_mux = res_pair[15:8];
      `ADDR_PINS: rd_mux = pin_s2_q & ~didr_q;
      default: begin
        rd_mux = 8'h00;
        addr_ok = 1'b0;
      end
    endcase
  end

  // APB answer: no wait state, ready in the first access cycle
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h0000_0000;
      pready <= 1'b0;
      pslverr <= 1'b0;
    end else begin
      pready <= psel & ~penable;
      pslverr <= psel & ~penable & ~addr_ok;
      prdata <= (psel & ~penable & ~pwrite) ? {24'h00_0000, rd_mux} : 32'h0000_0000;
    end
  end

  // Interrupt request
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq_req <= 1'b0;
    end else begin
      irq_req <= ctrl_a_q[`A_DONE] & ctrl_a_q[`A_IE] & gie_s2_q;
    end
  end

  // Converter power
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      conv_power <= 1'b0;
    end else begin
      conv_power <= ctrl_a_q[`A_ON];
    end
  end

  // Input buffer control and masked pin view
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      input_buf_off <= 8'h00;
      pin_view <= 8'h00;
    end else begin
      input_buf_off <= didr_q;
      pin_view <= pin_s2_q & ~didr_q;
    end
  end
endmodule // conv_ctrl

// *** tb/conv_ctrl_checker.sv ***
// Port assertions for the converter control block
`timescale 1ns/1ps
`include "conv_ctrl_regs.vh"
module conv_ctrl_checker (
  input wire pclk,
  input wire presetn,
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [11:0] paddr,
  input wire [31:0] pwdata,
  input wire [31:0] prdata,
  input wire pready,
  input wire pslverr,
  input wire global_irq_enable,
  input wire irq_req,
  input wire conv_power,
  input wire [7:0] input_buf_off,
  input wire [7:0] pin_view
);
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);
  wire wr = psel && penable && pready && pwrite;
  chk_ready_setup: assert property (psel && !penable |=> pready) else $error("ready missing");
  chk_ready_pulse: assert property (pready |=> !pready) else $error("ready too long");
  chk_err_unmapped: assert property (pready |-> pslverr == !(paddr inside {`ADDR_DIDR, `ADDR_CTRLB,
    `ADDR_RESL, `ADDR_RESH, `ADDR_CTRLA, `ADDR_PINS})) else $error("bad error flag");
  chk_idle_data: assert property (!pready |-> prdata == 32'h0000_0000) else $error("read data not zero");
  chk_power_write: assert property (wr && paddr == `ADDR_CTRLA |-> ##2 conv_power == $past(pwdata[`A_ON], 2))
    else $error("power bit wrong");
  chk_off_write: assert property (wr && paddr == `ADDR_DIDR |-> ##2 input_buf_off == $past(pwdata[7:0], 2))
    else $error("disable register wrong");
  chk_pin_masked: assert property ($stable(input_buf_off) |-> (pin_view & input_buf_off) == 8'h00)
    else $error("disabled pin reads one");
  chk_irq_global: assert property (!global_irq_enable [*4] |-> !irq_req)
    else $error("irq without global enable");
  cover property (irq_req);
  cover property (pready && pslverr);
  cover property ($rose(conv_power));
endmodule // conv_ctrl_checker

bind conv_ctrl conv_ctrl_checker conv_ctrl_checker_i (.*);

// *** tb/testbench.sv ***
// Self-checking bench for the converter control block
`timescale 1ns/1ps
`include "conv_ctrl_regs.vh"
module testbench;
  logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, global_irq_enable = 0, irq_ack = 0;
  logic [11:0] paddr = '0;
  logic [31:0] pwdata = '0, prdata, rd;
  logic pready, pslverr, irq_req, conv_power, err;
  logic [9:0] sample_pos = '0, sample_neg = '0;
  logic [6:0] trig_src = '0;
  logic [7:0] pin_in = 8'ha5, input_buf_off, pin_view;
  int bad_count = 0, check_count = 0, cyc = 0, n;
  // Address, write data, read data, error
  logic [28:0] rows [4] = '{{`ADDR_CTRLB, 8'h28, 8'h28, 1'b0}, {`ADDR_DIDR, 8'h0f, 8'h0f, 1'b0},
    {`ADDR_RESL, 8'hff, 8'h00, 1'b0}, {12'h030, 8'hff, 8'h00, 1'b1}};
  logic [11:0] ra [5] = '{`ADDR_DIDR, `ADDR_CTRLB, `ADDR_RESL, `ADDR_RESH, `ADDR_CTRLA};
  conv_ctrl conv_ctrl_i (.*);
  initial forever #50 pclk = ~pclk;
  always @(posedge pclk) begin
    cyc++;
    if (cyc == 20000) begin
      bad_count++;
      finish_test;
    end
  end
  task finish_test;
    $display("checks %0d mismatches %0d", check_count, bad_count);
    if (bad_count == 0 && check_count > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  task chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      bad_count++;
      $display("mismatch %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task apb(input logic w, input logic [11:0] a, input logic [7:0] d);
    @(posedge pclk);
    psel <= 1;
    penable <= 0;
    pwrite <= w;
    paddr <= a;
    pwdata <= {24'h00_0000, d};
    @(posedge pclk);
    penable <= 1;
    do @(posedge pclk); while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 0;
    penable <= 0;
  endtask
  task rdchk(input logic [11:0] a, input logic [7:0] e, input string nm);
    apb(1'b0, a, 8'h00);
    chk(nm, rd, {24'h00_0000, e});
  endtask
  // Cycles from the launching write until the interrupt request rises
  task wirq;
    n = 2;
    repeat (2) @(posedge pclk);
    while (irq_req !== 1'b1 && n < 3000) begin
      @(posedge pclk);
      n++;
    end
  endtask
  task cv(input logic [7:0] c);
    apb(1'b1, `ADDR_CTRLA, c);
    wirq;
  endtask
  initial begin
    repeat (5) @(posedge pclk);
    presetn <= 1;
    foreach (ra[i]) rdchk(ra[i], 8'h00, "reset_value");
    for (int i = 0; i < 4; i++) begin
      apb(1'b1, rows[i][28:17], rows[i][16:9]);
      apb(1'b0, rows[i][28:17], 8'h00);
      chk("row_data", rd, {24'h00_0000, rows[i][8:1]});
      chk("row_err", err, rows[i][0]);
    end
    rdchk(`ADDR_RESH, 8'h00, "unlock_h");
    chk("pin_view", pin_view, 8'ha0);
    $display("register test done");
    sample_pos <= 10'h2c5;
    global_irq_enable <= 1;
    cv(8'hc8);
    chk("first_len", n >= 48 && n <= 56, 1);
    chk("power", conv_power, 1);
    rdchk(`ADDR_CTRLA, 8'h98, "ctrl_a");
    rdchk(`ADDR_RESL, 8'hc5, "right_l");
    rdchk(`ADDR_RESH, 8'h02, "right_h");
    apb(1'b1, `ADDR_CTRLA, 8'h98);
    repeat (3) @(posedge pclk);
    chk("wr_clear", irq_req, 0);
    apb(1'b1, `ADDR_CTRLB, 8'h38);
    rdchk(`ADDR_RESL, 8'h40, "left_l");
    sample_pos <= 10'h13a;
    cv(8'hdb);
    chk("next_len", n >= 100 && n <= 110, 1);
    rdchk(`ADDR_RESH, 8'hb1, "locked_h");
    cv(8'hdb);
    rdchk(`ADDR_RESL, 8'h80, "new_l");
    rdchk(`ADDR_RESH, 8'h4e, "new_h");
    sample_pos <= 10'h010;
    sample_neg <= 10'h020;
    for (int b = 0; b < 2; b++) begin
      apb(1'b1, `ADDR_CTRLB, b ? 8'h80 : 8'h00);
      cv(8'hd8);
      rdchk(`ADDR_RESL, b ? 8'hf0 : 8'h00, "signed_l");
      rdchk(`ADDR_RESH, b ? 8'h03 : 8'h00, "signed_h");
    end
    $display("conversion test done");
    apb(1'b1, `ADDR_CTRLA, 8'hd0);
    apb(1'b1, `ADDR_CTRLA, 8'h00);
    repeat (60) @(posedge pclk);
    rdchk(`ADDR_CTRLA, 8'h00, "abort");
    chk("power_off", conv_power, 0);
    trig_src <= 7'h04;
    apb(1'b1, `ADDR_CTRLB, 8'h01);
    apb(1'b1, `ADDR_CTRLA, 8'hb8);
    repeat (20) @(posedge pclk);
    chk("no_trig", irq_req, 0);
    apb(1'b1, `ADDR_CTRLB, 8'h03);
    wirq;
    chk("trig_len", n >= 48 && n <= 60, 1);
    irq_ack <= 1;
    @(posedge pclk);
    irq_ack <= 0;
    repeat (3) @(posedge pclk);
    chk("ack_clear", irq_req, 0);
    apb(1'b1, `ADDR_CTRLB, 8'h00);
    repeat (60) @(posedge pclk);
    chk("free_select", irq_req, 0);
    $display("trigger test done");
    finish_test;
  end
endmodule // testbench
